// [rtl/mccr_pkg.sv]
// Package: register map, field layout and reset values of the capture/compare register set
`default_nettype none
package mccr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] PREV_CAPTURE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CURR_CAPTURE_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] NEXT_COMPARE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] DEMAG_VALUE_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] WEIGHT_VALUE_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] PRESCALE_OFS     = 8'h14;
  localparam logic [ADDR_W-1:0] MAIN_CONTROL_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] STATUS_OFS       = 8'h1C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SAMPLING_LSB   = 4;
  localparam int unsigned STEP_LSB       = 0;
  localparam int unsigned RATIO_W        = 4;
  localparam int unsigned CTRL_AUTO_BIT  = 0;
  localparam int unsigned CTRL_SPEED_BIT = 1;
  localparam int unsigned CTRL_MSEL_BIT  = 2;
  localparam int unsigned CTRL_ENC_BIT   = 3;
  localparam int unsigned CTRL_W         = 4;
  localparam int unsigned STAT_BLOCK_BIT = 0;
  localparam int unsigned STAT_INC_BIT   = 1;
  localparam int unsigned STAT_DEC_BIT   = 2;
  localparam int unsigned MUL_SHIFT      = 8;

  // ****************************************************************
  // Reset values, step-ratio limits and step size
  // ****************************************************************
  localparam logic [BYTE_W-1:0]  PREV_CAPTURE_RST = 8'h00;
  localparam logic [BYTE_W-1:0]  CURR_CAPTURE_RST = 8'h00;
  localparam logic [BYTE_W-1:0]  NEXT_COMPARE_RST = 8'h00;
  localparam logic [BYTE_W-1:0]  DEMAG_VALUE_RST  = 8'h00;
  localparam logic [BYTE_W-1:0]  WEIGHT_VALUE_RST = 8'h00;
  localparam logic [RATIO_W-1:0] RATIO_RST        = 4'h0;
  localparam logic [CTRL_W-1:0]  CTRL_RST         = 4'h0;
  localparam logic [RATIO_W-1:0] RATIO_MAX        = 4'hF;
  localparam logic [RATIO_W-1:0] RATIO_MIN        = 4'h0;
  localparam logic [RATIO_W-1:0] RATIO_STEP       = 4'h1;
endpackage : mccr_pkg
`default_nettype wire

// [rtl/mccr_mul_if.sv]
// Interface: operand, weight and scaled result of the compare computation
`default_nettype none
interface mccr_mul_if;
  import mccr_pkg::*;
  logic [BYTE_W-1:0] operand;
  logic [BYTE_W-1:0] weight;
  logic [BYTE_W-1:0] result;
  modport requester (output operand, output weight, input result);
  modport provider  (input operand, input weight, output result);
endinterface : mccr_mul_if
`default_nettype wire

// [rtl/mccr_weight_mul.sv]
// Weighted compare computation: operand times weight, divided by 256
`default_nettype none
module mccr_weight_mul (
  mccr_mul_if.provider mul
);
  import mccr_pkg::*;
  logic [2*BYTE_W-1:0] product;

  assign product    = mul.operand * mul.weight;
  assign mul.result = product[2*BYTE_W-1:MUL_SHIFT];
endmodule : mccr_weight_mul
`default_nettype wire

// [rtl/mccr_top.sv]
// Capture, compare and prescaler register set of the motor controller, APB slave
//
// What this block does
// - Switched/autoswitched: previous-capture holds the capture taken before the latest.
// - Speed mode: previous-capture holds low byte of the 16-bit timer capture.
// - Switched/autoswitched: current-capture holds the latest back-EMF capture.
// - Speed mode: current-capture holds high byte of the 16-bit timer capture.
// - Speed mode: reading current-capture blocks captures until previous-capture is read.
// - Next-commutation compare register is the compare value for next commutation.
// - Weight register provides the multiplier operand.
// - Autoswitched: each Z event loads compare with capture times weight over 256.
// - Control bit selects latest or previous capture as multiplicand.
// - Four-bit sampling-ratio field sets current-mode sampling frequency.
// - Step-ratio field, bits 3 to 0, prescales the commutation timer.
// - Step ratio increments on ratio-increment, decrements on ratio-decrement events.
// - Previous-capture register clears to zero on reset.
// - Encoder speed mode: timer high-byte read captures counter pair into both registers.
// - Switched: pending increment applies at next commutation, timer registers shift right.
// - Switched: pending decrement applies at next commutation, timer registers shift left.
//
// The address map and the APB slave port were left to the implementer.
`default_nettype none
module mccr_top (
  input  wire logic                            mclk_i,
  input  wire logic                            nrst_i,
  // APB slave
  input  wire logic                            psel_i,
  input  wire logic                            penable_i,
  input  wire logic                            pwrite_i,
  input  wire logic [mccr_pkg::ADDR_W-1:0]     paddr_i,
  input  wire logic [mccr_pkg::DATA_W-1:0]     pwdata_i,
  output logic      [mccr_pkg::DATA_W-1:0]     prdata_o,
  output logic                                 pready_o,
  output logic                                 pslverr_o,
  // Motor position sensing events
  input  wire logic                            z_event_i,
  input  wire logic [mccr_pkg::BYTE_W-1:0]     bemf_capture_i,
  input  wire logic                            speed_capture_i,
  input  wire logic                            timer_high_read_i,
  input  wire logic [2*mccr_pkg::BYTE_W-1:0]   timer_value_i,
  input  wire logic                            ratio_inc_i,
  input  wire logic                            ratio_dec_i,
  input  wire logic                            commutation_i,
  // Values to the commutation logic
  output logic      [mccr_pkg::BYTE_W-1:0]     next_compare_value_o,
  output logic      [mccr_pkg::BYTE_W-1:0]     demag_value_o,
  output logic      [mccr_pkg::BYTE_W-1:0]     weight_value_o,
  output logic      [mccr_pkg::RATIO_W-1:0]    sampling_ratio_o,
  output logic      [mccr_pkg::RATIO_W-1:0]    step_ratio_o,
  output logic                                 timer_shift_right_o,
  output logic                                 timer_shift_left_o,
  output logic                                 capture_blocked_o
);
  import mccr_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [BYTE_W-1:0]  previous_capture_value;
  logic [BYTE_W-1:0]  current_capture_value;
  logic [RATIO_W-1:0] sampling_ratio;
  logic [RATIO_W-1:0] step_ratio;
  logic [CTRL_W-1:0]  main_control;
  logic               pend_inc;
  logic               pend_dec;
  logic               capture_blocked;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire               acc_phase = psel_i & penable_i & ~pready_o;
  wire               acc_done  = psel_i & penable_i & pready_o;
  wire               wr_done   = acc_done & pwrite_i;
  wire               rd_done   = acc_done & ~pwrite_i;
  wire               hit_prev  = paddr_i == PREV_CAPTURE_OFS;
  wire               hit_curr  = paddr_i == CURR_CAPTURE_OFS;
  wire               hit_comp  = paddr_i == NEXT_COMPARE_OFS;
  wire               hit_demag = paddr_i == DEMAG_VALUE_OFS;
  wire               hit_wght  = paddr_i == WEIGHT_VALUE_OFS;
  wire               hit_pres  = paddr_i == PRESCALE_OFS;
  wire               hit_ctrl  = paddr_i == MAIN_CONTROL_OFS;
  wire               hit_stat  = paddr_i == STATUS_OFS;
  wire               addr_hit  = hit_prev | hit_curr | hit_comp | hit_demag | hit_wght |
                                 hit_pres | hit_ctrl | hit_stat;
  wire [BYTE_W-1:0]  wr_byte   = pwdata_i[BYTE_W-1:0];

  // ****************************************************************
  // Per-register write strobes
  // ****************************************************************
  wire wr_prev  = wr_done & hit_prev;
  wire wr_curr  = wr_done & hit_curr;
  wire wr_comp  = wr_done & hit_comp;
  wire wr_demag = wr_done & hit_demag;
  wire wr_wght  = wr_done & hit_wght;
  wire wr_pres  = wr_done & hit_pres;
  wire wr_ctrl  = wr_done & hit_ctrl;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  wire speed_mode    = main_control[CTRL_SPEED_BIT];
  wire auto_mode     = main_control[CTRL_AUTO_BIT] & ~speed_mode;
  wire switched_mode = ~main_control[CTRL_AUTO_BIT] & ~speed_mode;
  wire encoder_read  = main_control[CTRL_ENC_BIT];
  wire bemf_capture  = z_event_i & ~speed_mode;
  // Encoder mode: high-byte read of the timer is the capture trigger
  wire speed_trigger = encoder_read ? timer_high_read_i : speed_capture_i;
  wire speed_take    = speed_mode & speed_trigger & ~capture_blocked;
  wire read_curr     = rd_done & hit_curr & speed_mode;
  wire read_prev     = rd_done & hit_prev;

  // ****************************************************************
  // Weighted compare computation
  // ****************************************************************
  mccr_mul_if mul_bus ();

  // Z(N-1) after this event is the capture standing now
  assign mul_bus.operand = main_control[CTRL_MSEL_BIT] ?
                           current_capture_value : bemf_capture_i;
  assign mul_bus.weight  = weight_value_o;

  mccr_weight_mul u_mul (
    .mul (mul_bus.provider)
  );

  wire auto_load = auto_mode & z_event_i;

  // ****************************************************************
  // Step ratio next value
  // ****************************************************************
  wire switched_inc = switched_mode & commutation_i & pend_inc;
  wire switched_dec = switched_mode & commutation_i & pend_dec;
  wire direct_inc   = ~switched_mode & ratio_inc_i;
  wire direct_dec   = ~switched_mode & ratio_dec_i;
  wire do_inc       = (switched_inc | direct_inc) & ~(switched_dec | direct_dec);
  wire do_dec       = (switched_dec | direct_dec) & ~(switched_inc | direct_inc);
  // Saturate rather than wrap: a wrapped prescaler would jump the speed range
  wire can_inc      = step_ratio != RATIO_MAX;
  wire can_dec      = step_ratio != RATIO_MIN;

  logic [RATIO_W-1:0] next_step_ratio;
  always_comb begin
    next_step_ratio = step_ratio;
    if (wr_pres) begin
      next_step_ratio = pwdata_i[STEP_LSB +: RATIO_W];
    end
    if (do_inc & can_inc) begin
      next_step_ratio = step_ratio + RATIO_STEP;
    end else if (do_dec & can_dec) begin
      next_step_ratio = step_ratio - RATIO_STEP;
    end
  end

  // New request in the commutation cycle stays pending: set wins
  wire next_pend_inc = switched_mode & (ratio_inc_i | (pend_inc & ~commutation_i));
  wire next_pend_dec = switched_mode & (ratio_dec_i | (pend_dec & ~commutation_i));

  // A saturated step ratio does not move, so the timer must not shift either
  wire next_shift_right = switched_inc & ~switched_dec & can_inc;
  wire next_shift_left  = switched_dec & ~switched_inc & can_dec;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (1'b1)
      hit_prev:  rd_mux[BYTE_W-1:0] = previous_capture_value;
      hit_curr:  rd_mux[BYTE_W-1:0] = current_capture_value;
      hit_comp:  rd_mux[BYTE_W-1:0] = next_compare_value_o;
      hit_demag: rd_mux[BYTE_W-1:0] = demag_value_o;
      hit_wght:  rd_mux[BYTE_W-1:0] = weight_value_o;
      hit_pres:  rd_mux[BYTE_W-1:0] = {sampling_ratio, step_ratio};
      hit_ctrl:  rd_mux[CTRL_W-1:0] = main_control;
      hit_stat: begin
        rd_mux[STAT_BLOCK_BIT] = capture_blocked;
        rd_mux[STAT_INC_BIT]   = pend_inc;
        rd_mux[STAT_DEC_BIT]   = pend_dec;
      end
      default:   rd_mux = '0;
    endcase
  end

  // ****************************************************************
  // Bus slave: one wait state, answer registered
  // ****************************************************************
  wire              next_pslverr = acc_phase & ~addr_hit;
  wire [DATA_W-1:0] next_prdata  = (acc_phase & ~pwrite_i) ? rd_mux : '0;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= acc_phase;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= next_pslverr;
    end
  end

  // Zero outside read answers, so stale bytes never sit on the bus
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      prdata_o <= '0;
    end else begin
      prdata_o <= next_prdata;
    end
  end

  // ****************************************************************
  // Capture registers
  // ****************************************************************
  // Hardware capture beats a software write in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      previous_capture_value <= PREV_CAPTURE_RST;
    end else if (bemf_capture) begin
      previous_capture_value <= current_capture_value;
    end else if (speed_take) begin
      previous_capture_value <= timer_value_i[BYTE_W-1:0];
    end else if (wr_prev) begin
      previous_capture_value <= wr_byte;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      current_capture_value <= CURR_CAPTURE_RST;
    end else if (bemf_capture) begin
      current_capture_value <= bemf_capture_i;
    end else if (speed_take) begin
      current_capture_value <= timer_value_i[2*BYTE_W-1:BYTE_W];
    end else if (wr_curr) begin
      current_capture_value <= wr_byte;
    end
  end

  // Capture lock keeps the two speed bytes coherent
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      capture_blocked <= 1'b0;
    end else if (read_curr) begin
      capture_blocked <= 1'b1;
    end else if (read_prev | ~speed_mode) begin
      capture_blocked <= 1'b0;
    end
  end

  // ****************************************************************
  // Compare, demagnetization and weight
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      next_compare_value_o <= NEXT_COMPARE_RST;
    end else if (auto_load) begin
      next_compare_value_o <= mul_bus.result;
    end else if (wr_comp) begin
      next_compare_value_o <= wr_byte;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      demag_value_o <= DEMAG_VALUE_RST;
    end else if (wr_demag) begin
      demag_value_o <= wr_byte;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      weight_value_o <= WEIGHT_VALUE_RST;
    end else if (wr_wght) begin
      weight_value_o <= wr_byte;
    end
  end

  // ****************************************************************
  // Prescaler, sampling ratio and control
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sampling_ratio <= RATIO_RST;
    end else if (wr_pres) begin
      sampling_ratio <= pwdata_i[SAMPLING_LSB +: RATIO_W];
    end
  end

  // Leaving speed mode also releases the capture lock
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      main_control <= CTRL_RST;
    end else if (wr_ctrl) begin
      main_control <= pwdata_i[CTRL_W-1:0];
    end
  end

  // ****************************************************************
  // Step ratio, pending requests and timer shifts
  // ****************************************************************
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      step_ratio <= RATIO_RST;
    end else begin
      step_ratio <= next_step_ratio;
    end
  end

  // Only switched mode holds a request until the next commutation
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pend_inc <= 1'b0;
      pend_dec <= 1'b0;
    end else begin
      pend_inc <= next_pend_inc;
      pend_dec <= next_pend_dec;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      timer_shift_right_o <= 1'b0;
      timer_shift_left_o  <= 1'b0;
    end else begin
      timer_shift_right_o <= next_shift_right;
      timer_shift_left_o  <= next_shift_left;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign sampling_ratio_o  = sampling_ratio;
  assign step_ratio_o      = step_ratio;
  assign capture_blocked_o = capture_blocked;
endmodule : mccr_top
`default_nettype wire

// [tb/mccr_top_chk.sv]
// Checker: port-level properties of the capture/compare register set
`default_nettype none
module mccr_top_chk
  import mccr_pkg::*;
(
  input wire logic                         mclk_i,
  input wire logic                         nrst_i,
  input wire logic                         psel_i,
  input wire logic                         penable_i,
  input wire logic                         pwrite_i,
  input wire logic [mccr_pkg::ADDR_W-1:0]  paddr_i,
  input wire logic [mccr_pkg::DATA_W-1:0]  prdata_o,
  input wire logic                         pready_o,
  input wire logic                         pslverr_o,
  input wire logic                         z_event_i,
  input wire logic                         ratio_inc_i,
  input wire logic                         ratio_dec_i,
  input wire logic                         commutation_i,
  input wire logic [mccr_pkg::BYTE_W-1:0]  next_compare_value_o,
  input wire logic [mccr_pkg::RATIO_W-1:0] step_ratio_o,
  input wire logic                         timer_shift_right_o,
  input wire logic                         timer_shift_left_o,
  input wire logic                         capture_blocked_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic done_w   = psel_i && penable_i && pready_o;
  wire logic wr_done  = done_w && pwrite_i;
  wire logic rd_done  = done_w && !pwrite_i;
  wire logic unmapped = (paddr_i[7:5] != 3'h0) || (paddr_i[1:0] != 2'h0);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  AST_WAIT_STATE: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("pready missing after one wait state");
  AST_READY_PULSE: assert property (pready_o |-> psel_i && penable_i ##1 !pready_o)
    else $error("pready outside access or too long");
  AST_RDATA_IDLE: assert property ((!(pready_o && !pwrite_i) || pslverr_o) |-> prdata_o == '0)
    else $error("read data not zero outside read answer");
  AST_ERR_DECODE: assert property (pready_o |-> pslverr_o == unmapped)
    else $error("error response does not match address decode");
  AST_ERR_PULSE: assert property (pslverr_o |-> pready_o)
    else $error("error response without ready");
  AST_COMPARE_CAUSE: assert property (
    $changed(next_compare_value_o) |-> $past(z_event_i || wr_done))
    else $error("compare changed without Z event or write");
  AST_STEP_CAUSE: assert property (
    $changed(step_ratio_o) |-> $past(wr_done || ratio_inc_i || ratio_dec_i || commutation_i))
    else $error("step ratio changed without cause");
  AST_STEP_ONE: assert property (
    $changed(step_ratio_o) && !$past(wr_done) |->
      step_ratio_o == 4'($past(step_ratio_o) + 4'h1) ||
      step_ratio_o == 4'($past(step_ratio_o) - 4'h1))
    else $error("step ratio moved by more than one");
  AST_BLOCK_SET: assert property (
    $rose(capture_blocked_o) |-> $past(rd_done && paddr_i == CURR_CAPTURE_OFS))
    else $error("capture lock set without current read");
  AST_BLOCK_CLR: assert property (
    $fell(capture_blocked_o) |-> $past(rd_done && paddr_i == PREV_CAPTURE_OFS ||
                                       wr_done && paddr_i == MAIN_CONTROL_OFS))
    else $error("capture lock cleared without previous read");
  AST_SHIFT_RIGHT: assert property (
    timer_shift_right_o |-> $past(commutation_i) && !timer_shift_left_o)
    else $error("right shift not tied to commutation");
  AST_SHIFT_LEFT: assert property (
    timer_shift_left_o |-> $past(commutation_i) ##1 !timer_shift_left_o)
    else $error("left shift not a single pulse after commutation");
endmodule : mccr_top_chk
`default_nettype wire

// [tb/mccr_sense_model.sv]
// Partner: position sensing events toward the register set
`default_nettype none
module mccr_sense_model (
  input  wire logic        clk_i,
  output logic             z_event_o,
  output logic             speed_capture_o,
  output logic             timer_high_read_o,
  output logic             ratio_inc_o,
  output logic             ratio_dec_o,
  output logic             commutation_o,
  output logic [7:0]       bemf_capture_o,
  output logic [15:0]      timer_value_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ev = 6'h00;
  assign {commutation_o, ratio_dec_o, ratio_inc_o} = ev[5:3];
  assign {timer_high_read_o, speed_capture_o, z_event_o} = ev[2:0];
  initial bemf_capture_o = 8'h00;
  initial timer_value_o = 16'h0000;
  // One-cycle event; k: 0 Z, 1 speed, 2 high read, 3 inc, 4 dec, 5 commutation
  task automatic fire(input int k, input logic [15:0] v);
    @(posedge clk_i);
    ev <= 6'h01 << k;
    bemf_capture_o <= v[7:0];
    timer_value_o <= v;
    @(posedge clk_i);
    ev <= 6'h00;
    // Data no longer valid once the event is gone
    bemf_capture_o <= ~v[7:0];
    timer_value_o <= ~v;
    #1;
  endtask : fire
endmodule : mccr_sense_model
`default_nettype wire

// [tb/mccr_top_tb_top.sv]
// Testbench: register access, capture, compare and step-ratio scenarios
`default_nettype none
module mccr_top_tb_top
  import mccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [7:0] x; logic r;} mccr_row_type;
  logic clk, rst_n, psel, pen, pwr, prdy, perr, z, spd, thr, inc, dec, com, shr, shl, blk;
  logic [7:0] paddr, bemf, cmp, dmg, wgt;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] tval;
  logic [3:0] sam, stp;
  int errors = 0;
  int check_count = 0;
  int i;
  mccr_row_type rows [9];

  mccr_sense_model i_sense (.clk_i(clk), .z_event_o(z), .speed_capture_o(spd),
    .timer_high_read_o(thr), .ratio_inc_o(inc), .ratio_dec_o(dec), .commutation_o(com),
    .bemf_capture_o(bemf), .timer_value_o(tval));
  mccr_top i_mccr_top (.mclk_i(clk), .nrst_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(prdy), .pslverr_o(perr), .z_event_i(z), .bemf_capture_i(bemf),
    .speed_capture_i(spd), .timer_high_read_i(thr), .timer_value_i(tval),
    .ratio_inc_i(inc), .ratio_dec_i(dec), .commutation_i(com),
    .next_compare_value_o(cmp), .demag_value_o(dmg), .weight_value_o(wgt),
    .sampling_ratio_o(sam), .step_ratio_o(stp), .timer_shift_right_o(shr),
    .timer_shift_left_o(shl), .capture_blocked_o(blk));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  // APB transfer; a wait that runs out closes the run
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (n == 16) begin
      errors++;
      end_of_test();
    end
    q = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(s, q, x);
  endtask : rdchk

  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, paddr, pwdata} = '0;
    rows = '{'{8'h00, 32'hFFFFFF5A, 8'h5A, 1'b0}, '{8'h04, 32'hA3, 8'hA3, 1'b0},
             '{8'h08, 32'h77, 8'h77, 1'b0}, '{8'h0C, 32'h3C, 8'h3C, 1'b0},
             '{8'h10, 32'h81, 8'h81, 1'b0}, '{8'h14, 32'h9E, 8'h9E, 1'b0},
             '{8'h18, 32'h00, 8'h00, 1'b0}, '{8'h1C, 32'hFF, 8'h00, 1'b0},
             '{8'h20, 32'h55, 8'h00, 1'b1}};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i++) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("row data", q, {24'h0, rows[i].x});
      chk("row error", {31'h0, perr}, {31'h0, rows[i].r});
    end
    chk("compare out", {24'h0, cmp}, 32'h77);
    chk("demag out", {24'h0, dmg}, 32'h3C);
    chk("weight out", {24'h0, wgt}, 32'h81);
    chk("ratio out", {24'h0, sam, stp}, 32'h9E);
    // Switched: two Z events shift the pair, compare untouched
    i_sense.fire(0, 16'h0040);
    i_sense.fire(0, 16'h0080);
    rdchk("curr Z", CURR_CAPTURE_OFS, 32'h80);
    rdchk("prev Z", PREV_CAPTURE_OFS, 32'h40);
    chk("compare kept", {24'h0, cmp}, 32'h77);
    apb(1'b1, WEIGHT_VALUE_OFS, 32'h40);
    apb(1'b1, MAIN_CONTROL_OFS, 32'h1);
    i_sense.fire(0, 16'h00C0);
    chk("auto latest", {24'h0, cmp}, (32'hC0 * 32'h40) >> MUL_SHIFT);
    apb(1'b1, WEIGHT_VALUE_OFS, 32'h80);
    apb(1'b1, MAIN_CONTROL_OFS, 32'h5);
    i_sense.fire(0, 16'h0010);
    chk("auto previous", {24'h0, cmp}, (32'hC0 * 32'h80) >> MUL_SHIFT);
    // Speed mode: second capture refused while locked
    apb(1'b1, MAIN_CONTROL_OFS, 32'h2);
    i_sense.fire(1, 16'hA55A);
    rdchk("speed msb", CURR_CAPTURE_OFS, 32'hA5);
    #1;
    chk("locked", {31'h0, blk}, 32'h1);
    i_sense.fire(1, 16'h1234);
    rdchk("speed lsb", PREV_CAPTURE_OFS, 32'h5A);
    #1;
    chk("unlocked", {31'h0, blk}, 32'h0);
    apb(1'b1, MAIN_CONTROL_OFS, 32'hA);
    i_sense.fire(2, 16'hBEEF);
    rdchk("enc msb", CURR_CAPTURE_OFS, 32'hBE);
    rdchk("enc lsb", PREV_CAPTURE_OFS, 32'hEF);
    // Direct ratio steps, saturating at the top
    apb(1'b1, MAIN_CONTROL_OFS, 32'h1);
    apb(1'b1, PRESCALE_OFS, 32'h3E);
    i_sense.fire(3, 16'h0);
    i_sense.fire(3, 16'h0);
    chk("inc top", {24'h0, sam, stp}, 32'h3F);
    i_sense.fire(4, 16'h0);
    chk("dec", {24'h0, sam, stp}, 32'h3E);
    // Switched: requests wait for commutation
    apb(1'b1, MAIN_CONTROL_OFS, 32'h0);
    apb(1'b1, PRESCALE_OFS, 32'h35);
    i_sense.fire(3, 16'h0);
    chk("inc pending", {28'h0, stp}, 32'h5);
    i_sense.fire(5, 16'h0);
    chk("shift right", {30'h0, shl, shr}, 32'h1);
    chk("inc applied", {28'h0, stp}, 32'h6);
    i_sense.fire(4, 16'h0);
    i_sense.fire(5, 16'h0);
    chk("shift left", {30'h0, shl, shr}, 32'h2);
    chk("dec applied", {28'h0, stp}, 32'h5);
    apb(1'b1, PRESCALE_OFS, 32'h0F);
    i_sense.fire(3, 16'h0);
    i_sense.fire(5, 16'h0);
    chk("saturated no shift", {30'h0, shl, shr}, 32'h0);
    chk("saturated step", {28'h0, stp}, 32'hF);
    // Second reset with a loaded previous capture
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("prev reset", PREV_CAPTURE_OFS, 32'h0);
    end_of_test();
  end
endmodule : mccr_top_tb_top

bind mccr_top mccr_top_chk i_mccr_top_chk (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .z_event_i(z_event_i), .ratio_inc_i(ratio_inc_i), .ratio_dec_i(ratio_dec_i),
  .commutation_i(commutation_i), .next_compare_value_o(next_compare_value_o),
  .step_ratio_o(step_ratio_o), .timer_shift_right_o(timer_shift_right_o),
  .timer_shift_left_o(timer_shift_left_o), .capture_blocked_o(capture_blocked_o));
`default_nettype wire
